// [sim/trps_checker.sv]
// port assertions for the three-rail power sequencer
`timescale 1ns/1ps
module trps_checker (
  input wire aclk,                  // clock
  input wire aresetn,               // sync reset, active low
  input wire seq_enable,            // sequence enable
  input wire awvalid,               // write address valid
  input wire awready,               // write address ready
  input wire wvalid,                // write data valid
  input wire wready,                // write data ready
  input wire bvalid,                // write response valid
  input wire arvalid,               // read address valid
  input wire arready,               // read address ready
  input wire rvalid,                // read data valid
  input wire rail_release_out_1_o,  // drive value 1
  input wire rail_release_out_2_o,  // drive value 2
  input wire rail_release_out_3_o,  // drive value 3
  input wire rail_release_out_1_oe, // pulling low 1
  input wire rail_release_out_2_oe, // pulling low 2
  input wire rail_release_out_3_oe  // pulling low 3
);
  // rails gathered, bit 0 is output one
  wire [2:0] oe = {rail_release_out_3_oe, rail_release_out_2_oe,
                   rail_release_out_1_oe};
  wire [2:0] drv = {rail_release_out_3_o, rail_release_out_2_o,
                    rail_release_out_1_o};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_drive_low: assert property (drv == 3'h0)
    else $error("rail output driven high");
  a_up_second: assert property ($fell(oe[1]) |-> !oe[0])
    else $error("rail two released before rail one");
  a_up_third: assert property ($fell(oe[2]) |-> oe[1:0] == 2'h0)
    else $error("rail three released too early");
  a_one_step: assert property ($onehot0(oe ^ $past(oe)))
    else $error("two rails changed together");
  a_idle_hold: assert property (
    oe == 3'h7 && !seq_enable |=> oe == 3'h7)
    else $error("rail released without enable");
  a_no_early: assert property ($fell(oe[0]) |-> $past(oe[0], 8))
    else $error("first release came too soon");
  // bus answers at the documented edges
  a_wr_answer: assert property (awvalid && awready && wvalid && wready
    |=> !awready && !wready ##1 bvalid)
    else $error("write response late");
  a_rd_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read response late");
endmodule // trps_checker

// [sim/trps_rail_model.sv]
// open-drain rail wires with pull-ups feeding regulator enables
`timescale 1ns/1ps
module trps_rail_model (
  input  wire [2:0] drive_oe, // high while the sequencer pulls low
  input  wire [2:0] drive_o,  // level driven while enabled
  output wire [2:0] pin       // resolved wire level
);
  // pull-up wins whenever the line is left undriven
  assign pin = (drive_oe & drive_o) | ~drive_oe;
endmodule // trps_rail_model

// [sim/trps_sequencer_bench.sv]
// self-checking bench for the three-rail power sequencer
`timescale 1ns/1ps
module trps_sequencer_bench;
  localparam integer E = 3;     // shortened first-step extra
  localparam integer HOLD = 25; // shortened settle before power-down
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg         seq_enable;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata;
  reg  [3:0]  wstrb;
  reg  [2:0]  awprot, arprot;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [2:0]  oe, drv, pin;
  integer     fail_count, checks, cyc, s;
  trps_sequencer #(.DLY_SHORT_CYC(24'd20), .DLY_STD_CYC(24'd30),
    .DLY_LONG_CYC(24'd40), .DLY_EXT_CYC(24'd50), .EXTRA_CYC(24'd3),
    .HOLD_CYC(24'd25)) dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .seq_enable(seq_enable), .rail_release_in_1(pin[0]),
    .rail_release_out_1_o(drv[0]), .rail_release_out_1_oe(oe[0]),
    .rail_release_in_2(pin[1]), .rail_release_out_2_o(drv[1]),
    .rail_release_out_2_oe(oe[1]), .rail_release_in_3(pin[2]),
    .rail_release_out_3_o(drv[2]), .rail_release_out_3_oe(oe[2]));
  trps_rail_model model (.drive_oe(oe), .drive_o(drv), .pin(pin));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task axi_write(input [7:0] a, input [31:0] d, input [1:0] er);
    reg done;
    begin
      @(posedge aclk);
      awaddr <= a;
      awprot <= d[2:0];
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid) begin
          check(bresp, er);
          bready <= 1'b0;
          done = 1'b1;
        end
      end
    end
  endtask
  task axi_read(input [7:0] a, input [31:0] ed, input [1:0] er);
    reg done;
    begin
      @(posedge aclk);
      araddr <= a;
      arprot <= a[4:2];
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid) begin
          check(rdata, ed);
          check(rresp, er);
          rready <= 1'b0;
          done = 1'b1;
        end
      end
    end
  endtask
  // cycles until rail i reaches level v, counted from the next edge
  task wait_oe(input integer i, input v, input integer exp);
    integer n;
    begin
      n = 0;
      while (oe[i] !== v && n < 400) begin
        @(posedge aclk);
        #1 n = n + 1;
      end
      check(n, exp);
    end
  endtask
  // enable pulse too short, then a drop in mid power-up
  task drop_scenario;
    begin
      @(posedge aclk);
      seq_enable <= 1'b1;
      repeat (5) @(posedge aclk);
      seq_enable <= 1'b0;
      repeat (60) @(posedge aclk);
      check(oe, 3'h7);
      seq_enable <= 1'b1;
      wait_oe(0, 1'b0, 1 + 30 + E);
      repeat (3) @(posedge aclk);
      seq_enable <= 1'b0;
      wait_oe(1, 1'b0, 1 + 30);
      wait_oe(2, 1'b0, 30);
      wait_oe(2, 1'b1, HOLD + 30 + E);
      wait_oe(1, 1'b1, 30);
      wait_oe(0, 1'b1, 30);
    end
  endtask
  // full cycle with timing option (sq-1)%4 and power-down order sq
  task run_seq(input integer sq);
    integer d;
    reg [5:0] ord;
    begin
      d = 20 + 10 * ((sq - 1) % 4);
      case (sq)
        1: ord = 6'b10_01_00;
        2: ord = 6'b10_00_01;
        3: ord = 6'b01_10_00;
        4: ord = 6'b01_00_10;
        5: ord = 6'b00_10_01;
        default: ord = 6'b00_01_10;
      endcase
      axi_write(8'h00, (sq << 4) | ((sq - 1) % 4), 2'h0);
      @(posedge aclk);
      seq_enable <= 1'b1;
      wait_oe(0, 1'b0, 1 + d + E);
      wait_oe(1, 1'b0, d);
      wait_oe(2, 1'b0, d);
      axi_read(8'h04, 32'h0010_007f, 2'h0);
      @(posedge aclk);
      seq_enable <= 1'b0;
      wait_oe(ord[5:4], 1'b1, 1 + d + E);
      wait_oe(ord[3:2], 1'b1, d);
      wait_oe(ord[1:0], 1'b1, d);
    end
  endtask
  // reset in mid power-up: rails back low, config back to default
  task reset_scenario;
    begin
      axi_write(8'h00, 32'h32, 2'h0);
      @(posedge aclk);
      seq_enable <= 1'b1;
      wait_oe(0, 1'b0, 1 + 40 + E);
      @(posedge aclk);
      aresetn <= 1'b0;
      seq_enable <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      check(oe, 3'h7);
      axi_read(8'h00, 32'h0000_0011, 2'h0);
      repeat (4) @(posedge aclk);
      check(oe, 3'h7);
    end
  endtask
  // free-running clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // hang guard, far beyond the longest expected run
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      wrap_up;
    end
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, seq_enable} = 7'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    {awprot, arprot} = 6'h0;
    {fail_count, checks, cyc} = 96'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    check(oe, 3'h7);
    axi_read(8'h00, 32'h0000_0011, 2'h0);
    axi_read(8'h04, 32'h0001_0000, 2'h0);
    axi_read(8'h08, 32'h0, 2'h2);
    axi_write(8'h04, 32'hff, 2'h0);
    axi_write(8'h08, 32'h3, 2'h2);
    // low byte strobe off: the write is answered but changes nothing
    wstrb <= 4'he;
    axi_write(8'h00, 32'h23, 2'h0);
    wstrb <= 4'hf;
    axi_read(8'h00, 32'h0000_0011, 2'h0);
    drop_scenario;
    for (s = 1; s < 7; s = s + 1) run_seq(s);
    reset_scenario;
    wrap_up;
  end
endmodule // trps_sequencer_bench
bind trps_sequencer trps_checker chk (.aclk(aclk), .aresetn(aresetn),
  .seq_enable(seq_enable), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid),
  .rail_release_out_1_o(rail_release_out_1_o),
  .rail_release_out_2_o(rail_release_out_2_o),
  .rail_release_out_3_o(rail_release_out_3_o),
  .rail_release_out_1_oe(rail_release_out_1_oe),
  .rail_release_out_2_oe(rail_release_out_2_oe),
  .rail_release_out_3_oe(rail_release_out_3_oe));

// [verilog/trps_consts.vh]
// constants of the three-rail power sequencer
`ifndef TRPS_CONSTS_VH
`define TRPS_CONSTS_VH

// clock rate
`define TRPS_CLK_HZ          50000000

// register byte offsets
`define TRPS_CFG_OFFSET      8'h00
`define TRPS_STATUS_OFFSET   8'h04

// configuration fields and reset value
`define TRPS_CFG_TOPT_LSB    0
`define TRPS_CFG_TOPT_MSB    1
`define TRPS_CFG_SEQ_LSB     4
`define TRPS_CFG_SEQ_MSB     6
`define TRPS_CFG_RESET       32'h0000_0011

// status fields
`define TRPS_ST_REL_LSB      0
`define TRPS_ST_EN_BIT       3
`define TRPS_ST_PIN_LSB      4
`define TRPS_ST_STATE_LSB    16

// timing option codes
`define TRPS_TOPT_SHORT      2'h0
`define TRPS_TOPT_STANDARD   2'h1
`define TRPS_TOPT_LONG       2'h2
`define TRPS_TOPT_EXTENDED   2'h3

// delay per timing option, milliseconds
`define TRPS_DLY_SHORT_MS    10
`define TRPS_DLY_STANDARD_MS 30
`define TRPS_DLY_LONG_MS     60
`define TRPS_DLY_EXT_MS      120

// extra time on first step of each sequence, microseconds
`define TRPS_EXTRA_US        400
// settle time before a deferred power-down, milliseconds
`define TRPS_HOLD_MS         120

// the same delays as clock cycles at 50 MHz, sized for the timers
`define TRPS_DLY_SHORT_CYC   24'd500000
`define TRPS_DLY_STD_CYC     24'd1500000
`define TRPS_DLY_LONG_CYC    24'd3000000
`define TRPS_DLY_EXT_CYC     24'd6000000
`define TRPS_EXTRA_CYC       24'd20000
`define TRPS_HOLD_CYC        24'd6000000

// bus responses
`define TRPS_RESP_OKAY       2'h0
`define TRPS_RESP_SLVERR     2'h2

`endif

// [verilog/trps_sequencer.v]
// three-rail power sequencer with an axi4-lite configuration slave
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "trps_consts.vh"

// Behaviour
// - power-up releases outputs singly, each own delay
// - power-down pulls outputs low singly, reversed default
// - up order 1-2-3; six down orders
// - timing option sets all six delays alike
// - delays 1-3 power-up, 4-6 power-down
// - outputs open drain: drive low or release
// - single enable input starts both sequences
// - all outputs low until first enable
// - early enable drop resets first timer
// - late drop: finish up, hold, then down
// - first up and down delays add 400us
module trps_sequencer #(
  parameter [23:0] DLY_SHORT_CYC = `TRPS_DLY_SHORT_CYC,
  parameter [23:0] DLY_STD_CYC   = `TRPS_DLY_STD_CYC,
  parameter [23:0] DLY_LONG_CYC  = `TRPS_DLY_LONG_CYC,
  parameter [23:0] DLY_EXT_CYC   = `TRPS_DLY_EXT_CYC,
  parameter [23:0] EXTRA_CYC     = `TRPS_EXTRA_CYC,
  parameter [23:0] HOLD_CYC      = `TRPS_HOLD_CYC
) (
  input  wire        aclk,                 // system clock, 50 MHz
  input  wire        aresetn,              // synchronous reset, active low
  input  wire [7:0]  awaddr,               // write address
  input  wire [2:0]  awprot,               // write protection, unused
  input  wire        awvalid,              // write address valid
  output reg         awready,              // write address ready
  input  wire [31:0] wdata,                // write data
  input  wire [3:0]  wstrb,                // write byte strobes
  input  wire        wvalid,               // write data valid
  output reg         wready,               // write data ready
  output reg  [1:0]  bresp,                // write response
  output reg         bvalid,               // write response valid
  input  wire        bready,               // write response ready
  input  wire [7:0]  araddr,               // read address
  input  wire [2:0]  arprot,               // read protection, unused
  input  wire        arvalid,              // read address valid
  output reg         arready,              // read address ready
  output reg  [31:0] rdata,                // read data
  output reg  [1:0]  rresp,                // read response
  output reg         rvalid,               // read data valid
  input  wire        rready,               // read data ready
  input  wire        seq_enable,           // sequence enable, high = up
  input  wire        rail_release_in_1,    // pin level, output 1
  output reg         rail_release_out_1_o, // pin drive value, always low
  output reg         rail_release_out_1_oe,// high while pulling low
  input  wire        rail_release_in_2,    // pin level, output 2
  output reg         rail_release_out_2_o, // pin drive value, always low
  output reg         rail_release_out_2_oe,// high while pulling low
  input  wire        rail_release_in_3,    // pin level, output 3
  output reg         rail_release_out_3_o, // pin drive value, always low
  output reg         rail_release_out_3_oe // high while pulling low
);

  // one-hot sequencer states
  localparam [8:0] ST_OFF  = 9'h001;
  localparam [8:0] ST_UP1  = 9'h002;
  localparam [8:0] ST_UP2  = 9'h004;
  localparam [8:0] ST_UP3  = 9'h008;
  localparam [8:0] ST_ON   = 9'h010;
  localparam [8:0] ST_HOLD = 9'h020;
  localparam [8:0] ST_DN1  = 9'h040;
  localparam [8:0] ST_DN2  = 9'h080;
  localparam [8:0] ST_DN3  = 9'h100;

  reg  [8:0]  state;
  reg  [23:0] cnt;
  reg         en_q;
  reg         pend_down;
  reg  [31:0] cfg;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  wire [1:0]  topt = cfg[`TRPS_CFG_TOPT_MSB:`TRPS_CFG_TOPT_LSB];
  wire [2:0]  seqo = cfg[`TRPS_CFG_SEQ_MSB:`TRPS_CFG_SEQ_LSB];
  wire [2:0]  drive_low = {rail_release_out_3_oe, rail_release_out_2_oe,
                           rail_release_out_1_oe};
  wire        en_fall = en_q & ~seq_enable;

  // one delay value for all six steps of the chosen option
  function [23:0] dly_cyc;
    input [1:0] opt;
    begin
      case (opt)
        `TRPS_TOPT_SHORT:    dly_cyc = DLY_SHORT_CYC;
        `TRPS_TOPT_STANDARD: dly_cyc = DLY_STD_CYC;
        `TRPS_TOPT_LONG:     dly_cyc = DLY_LONG_CYC;
        default:             dly_cyc = DLY_EXT_CYC;
      endcase
    end
  endfunction

  // rail mask pulled low at a power-down step; bad codes act as option 1
  function [2:0] dn_rail;
    input [2:0] seq;
    input [1:0] step;
    reg   [8:0] ord;
    begin
      case (seq)
        3'h2:    ord = {3'b010, 3'b001, 3'b100};
        3'h3:    ord = {3'b001, 3'b100, 3'b010};
        3'h4:    ord = {3'b100, 3'b001, 3'b010};
        3'h5:    ord = {3'b010, 3'b100, 3'b001};
        3'h6:    ord = {3'b100, 3'b010, 3'b001};
        default: ord = {3'b001, 3'b010, 3'b100};
      endcase
      case (step)
        2'h0:    dn_rail = ord[2:0];
        2'h1:    dn_rail = ord[5:3];
        default: dn_rail = ord[8:6];
      endcase
    end
  endfunction

  // terminal counts, one less since the count starts at zero
  wire [23:0] step_tgt  = dly_cyc(topt) - 24'h1;
  wire [23:0] first_tgt = dly_cyc(topt) + EXTRA_CYC - 24'h1;
  wire [23:0] hold_tgt  = HOLD_CYC - 24'h1;

  // sequencer; each timer restarts when its state is entered, and in ST_UP2/ST_UP3 again at an enable drop
  always @(posedge aclk) begin
    if (!aresetn) begin
      state     <= ST_OFF;
      cnt       <= 24'h0;
      en_q      <= 1'b0;
      pend_down <= 1'b0;
      rail_release_out_1_oe <= 1'b1;
      rail_release_out_2_oe <= 1'b1;
      rail_release_out_3_oe <= 1'b1;
    end else begin
      en_q <= seq_enable;
      cnt  <= cnt + 24'h1;
      case (state)
        ST_OFF: begin
          pend_down <= 1'b0;
          cnt       <= 24'h0;
          if (seq_enable) begin
            state <= ST_UP1;
          end
        end
        ST_UP1: begin
          if (!seq_enable) begin
            state <= ST_OFF;
            cnt   <= 24'h0;
          end else if (cnt == first_tgt) begin
            rail_release_out_1_oe <= 1'b0;
            state <= ST_UP2;
            cnt   <= 24'h0;
          end
        end
        ST_UP2: begin
          if (!seq_enable) begin
            pend_down <= 1'b1;
          end
          if (cnt == step_tgt) begin
            rail_release_out_2_oe <= 1'b0;
            state <= ST_UP3;
            cnt   <= 24'h0;
          end else if (en_fall) begin
            cnt <= 24'h0;
          end
        end
        ST_UP3: begin
          if (!seq_enable) begin
            pend_down <= 1'b1;
          end
          if (cnt == step_tgt) begin
            rail_release_out_3_oe <= 1'b0;
            cnt   <= 24'h0;
            // a drop after output one is released waits for the settle time
            if (pend_down || !seq_enable) begin
              state <= ST_HOLD;
            end else begin
              state <= ST_ON;
            end
          end else if (en_fall) begin
            cnt <= 24'h0;
          end
        end
        ST_ON: begin
          cnt <= 24'h0;
          if (!seq_enable) begin
            state <= ST_DN1;
          end
        end
        ST_HOLD: begin
          // a re-enable here is not honoured; down runs to the end
          if (cnt == hold_tgt) begin
            state <= ST_DN1;
            cnt   <= 24'h0;
          end
        end
        ST_DN1: begin
          if (cnt == first_tgt) begin
            {rail_release_out_3_oe, rail_release_out_2_oe,
             rail_release_out_1_oe} <= drive_low | dn_rail(seqo, 2'h0);
            state <= ST_DN2;
            cnt   <= 24'h0;
          end
        end
        ST_DN2: begin
          if (cnt == step_tgt) begin
            {rail_release_out_3_oe, rail_release_out_2_oe,
             rail_release_out_1_oe} <= drive_low | dn_rail(seqo, 2'h1);
            state <= ST_DN3;
            cnt   <= 24'h0;
          end
        end
        ST_DN3: begin
          if (cnt == step_tgt) begin
            rail_release_out_1_oe <= 1'b1;
            rail_release_out_2_oe <= 1'b1;
            rail_release_out_3_oe <= 1'b1;
            state <= ST_OFF;
            cnt   <= 24'h0;
          end
        end
        default: begin
          state <= ST_OFF;
          cnt   <= 24'h0;
        end
      endcase
    end
  end

  // open drain: the drive value never leaves low
  always @(posedge aclk) begin
    rail_release_out_1_o <= 1'b0;
    rail_release_out_2_o <= 1'b0;
    rail_release_out_3_o <= 1'b0;
  end

  // write channel; address and data are taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `TRPS_RESP_OKAY;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      cfg     <= `TRPS_CFG_RESET;
    end else begin
      if (awready && awvalid) begin
        aw_addr <= awaddr;
        awready <= 1'b0;
      end
      if (wready && wvalid) begin
        w_data <= wdata;
        w_strb <= wstrb;
        wready <= 1'b0;
      end
      // both halves held and no answer pending: commit the write
      if (!awready && !wready && !bvalid) begin
        bvalid <= 1'b1;
        if (aw_addr[7:2] == `TRPS_CFG_OFFSET >> 2) begin
          bresp <= `TRPS_RESP_OKAY;
          if (w_strb[0]) begin
            cfg[`TRPS_CFG_TOPT_MSB:`TRPS_CFG_TOPT_LSB] <=
              w_data[`TRPS_CFG_TOPT_MSB:`TRPS_CFG_TOPT_LSB];
            cfg[`TRPS_CFG_SEQ_MSB:`TRPS_CFG_SEQ_LSB] <=
              w_data[`TRPS_CFG_SEQ_MSB:`TRPS_CFG_SEQ_LSB];
          end
        end else if (aw_addr[7:2] == `TRPS_STATUS_OFFSET >> 2) begin
          bresp <= `TRPS_RESP_OKAY; // read-only, write ignored
        end else begin
          bresp <= `TRPS_RESP_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // read channel; status shows live sequencer state and pin levels
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `TRPS_RESP_OKAY;
    end else begin
      if (arready && arvalid) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= 32'h0;
        rresp   <= `TRPS_RESP_OKAY;
        if (araddr[7:2] == `TRPS_CFG_OFFSET >> 2) begin
          rdata <= cfg;
        end else if (araddr[7:2] == `TRPS_STATUS_OFFSET >> 2) begin
          rdata[`TRPS_ST_REL_LSB +: 3]   <= ~drive_low;
          rdata[`TRPS_ST_EN_BIT]         <= seq_enable;
          rdata[`TRPS_ST_PIN_LSB +: 3]   <= {rail_release_in_3,
                                             rail_release_in_2,
                                             rail_release_in_1};
          rdata[`TRPS_ST_STATE_LSB +: 9] <= state;
        end else begin
          rresp <= `TRPS_RESP_SLVERR;
        end
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule // trps_sequencer
